/* File: hw/aspc_defines.vh */
// register offsets, field positions, reset values and codes for the aux port clock generator
`ifndef ASPC_DEFINES_VH
`define ASPC_DEFINES_VH
`define ASPC_ADDR_DIV_SOURCE   8'h64
`define ASPC_ADDR_BIT_RATIO    8'h65
`define ASPC_ADDR_WORD_HIGH    8'h66
`define ASPC_ADDR_WORD_LOW     8'h67
`define ASPC_ADDR_BCLK_PIN     8'h68
`define ASPC_ADDR_WCLK_PIN     8'h69
`define ASPC_ADDR_LINK_MODE    8'h61
`define ASPC_ADDR_DEV_NUMBER   8'h62
`define ASPC_RST_DIV_SOURCE    8'h01
`define ASPC_RST_BIT_RATIO     8'h02
`define ASPC_RST_WORD_HIGH     8'h00
`define ASPC_RST_WORD_LOW      8'h20
`define ASPC_RST_BCLK_PIN      8'h40
`define ASPC_RST_WCLK_PIN      8'h38
`define ASPC_RST_LINK_MODE     8'h08
`define ASPC_RST_DEV_NUMBER    8'h00
`define ASPC_BIT_DIR           7
`define ASPC_WORD_DIR          6
`define ASPC_SRC_HI            2
`define ASPC_SRC_LO            0
`define ASPC_PWR_BIT           7
`define ASPC_RATIO_HI          6
`define ASPC_WHIGH_HI          1
`define ASPC_PIN_HI            6
`define ASPC_PIN_LO            3
`define ASPC_LINK_BIT          7
`define ASPC_DEVNUM_HI         2
`define ASPC_SRC_RESERVED      3'h2
`define ASPC_PIN_CODES         16
`endif

/* File: hw/aspc_divider.v */
// programmable divider producing a one-cycle tick every ratio input events
`timescale 1ns/1ps
module aspc_divider #(
  parameter W = 7                     // counter width; ratio 0 means 2**W
) (
  input  wire         clk,            // system clock
  input  wire         rst_n,          // synchronised reset, active low
  input  wire         powerUp,        // divider enable
  input  wire         stepIn,         // one input event this cycle
  input  wire [W-1:0] ratio,          // division ratio, 0 means 2**W
  output reg          tickOut         // one-cycle pulse per division
);
  reg [W-1:0] count_r;                // events seen since last tick

  // count events; a zero ratio wraps naturally after 2**W events
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= {W{1'b0}};
      tickOut <= 1'b0;
    end else if (!powerUp) begin      // held idle, no ticks at all
      count_r <= {W{1'b0}};
      tickOut <= 1'b0;
    end else if (stepIn) begin
      if (count_r + {{(W-1){1'b0}}, 1'b1} == ratio) begin
        count_r <= {W{1'b0}};
        tickOut <= 1'b1;
      end else begin
        count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
        tickOut <= 1'b0;
      end
    end else begin
      tickOut <= 1'b0;
    end
  end
endmodule // aspc_divider

/* File: hw/aspc_clock_gen.v */
// aux serial port bit and word clock generator with its register file
// Notes on behaviour
// (RL1) bit clock direction bit seven; output only device one
// (RL2) word clock direction bit six
// (RL3) three-bit source field picks divider input
// (RL4) bit divider power bit, reset down
// (RL5) bit ratio 1..127, zero means 128
// (RL6) word divider power bit, reset down
// (RL7) word frame every N bit ticks, zero 1024
// (RL8) word ratio from two registers, high then low
// (RL9) four-bit bit clock pin select, reset code eight
// (RL10) word clock pin select register, reset 38h
// (RL11) link type bit selects multichip or conventional
// (RL12) device number field, codes mean one to eight
// (RL13) powered-down divider gives no edges, no drive
`timescale 1ns/1ps
`include "aspc_defines.vh"
module aspc_clock_gen (
  input  wire        clk,             // 200 MHz system clock
  input  wire        nrst,            // asynchronous reset, active low
  input  wire        regWrite,        // register write strobe
  input  wire        regRead,         // register read strobe
  input  wire [7:0]  regAddr,         // register address
  input  wire [7:0]  regWdata,        // write data
  output reg  [7:0]  regRdata,        // read data, valid cycle after read
  input  wire        nDividerClk,     // on-chip n-divider clock level
  input  wire        dacModClk,       // dac modulator clock level
  input  wire        adcModClk,       // adc modulator clock level
  input  wire [3:0]  portBitClkPins,  // port1 dac/adc, port2 dac/adc bit clock pins
  input  wire [9:0]  gpioIn,          // general i/o pins 1..10 input
  input  wire [2:0]  gpiIn,           // general input pins 1..3
  output reg  [9:0]  gpioOut,         // general i/o pins output level
  output reg  [9:0]  gpioOe,          // general i/o pins output enable
  output reg         bitClkIn,        // selected external bit clock level
  output reg         wordClkIn,       // selected external word clock level
  output reg         bitClkOut,       // generated bit clock level
  output reg         wordClkOut       // generated word frame clock level
);
  // reset synchroniser
  reg rstMeta_r;                      // first stage, read only by second
  reg rstSync_r;                      // released reset for the design
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  reg [7:0] divSource_r;              // directions and source select
  reg [7:0] bitRatio_r;               // bit divider power and ratio
  reg [7:0] wordHigh_r;               // word divider power and ratio msbs
  reg [7:0] wordLow_r;                // word ratio lsbs
  reg [7:0] bclkPin_r;                // bit clock pin code
  reg [7:0] wclkPin_r;                // word clock pin code
  reg [7:0] linkMode_r;               // link type select
  reg [7:0] devNumber_r;              // local device number

  // register writes; reserved bits kept as written (read/write)
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      divSource_r <= `ASPC_RST_DIV_SOURCE;   // [RL3]
      bitRatio_r  <= `ASPC_RST_BIT_RATIO;    // [RL4] [RL5]
      wordHigh_r  <= `ASPC_RST_WORD_HIGH;    // [RL6]
      wordLow_r   <= `ASPC_RST_WORD_LOW;     // [RL7]
      bclkPin_r   <= `ASPC_RST_BCLK_PIN;     // [RL9]
      wclkPin_r   <= `ASPC_RST_WCLK_PIN;     // [RL10]
      linkMode_r  <= `ASPC_RST_LINK_MODE;
      devNumber_r <= `ASPC_RST_DEV_NUMBER;
    end else if (regWrite) begin
      if (regAddr == `ASPC_ADDR_DIV_SOURCE) begin
        divSource_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_BIT_RATIO) begin
        bitRatio_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_WORD_HIGH) begin
        wordHigh_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_WORD_LOW) begin
        wordLow_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_BCLK_PIN) begin
        bclkPin_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_WCLK_PIN) begin
        wclkPin_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_LINK_MODE) begin
        linkMode_r <= regWdata;
      end else if (regAddr == `ASPC_ADDR_DEV_NUMBER) begin
        devNumber_r <= regWdata;
      end
    end
  end

  // register reads; unmapped addresses return zero
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `ASPC_ADDR_DIV_SOURCE) begin
        regRdata <= divSource_r;
      end else if (regAddr == `ASPC_ADDR_BIT_RATIO) begin
        regRdata <= bitRatio_r;
      end else if (regAddr == `ASPC_ADDR_WORD_HIGH) begin
        regRdata <= wordHigh_r;
      end else if (regAddr == `ASPC_ADDR_WORD_LOW) begin
        regRdata <= wordLow_r;
      end else if (regAddr == `ASPC_ADDR_BCLK_PIN) begin
        regRdata <= bclkPin_r;
      end else if (regAddr == `ASPC_ADDR_WCLK_PIN) begin
        regRdata <= wclkPin_r;
      end else if (regAddr == `ASPC_ADDR_LINK_MODE) begin
        regRdata <= linkMode_r;
      end else if (regAddr == `ASPC_ADDR_DEV_NUMBER) begin
        regRdata <= devNumber_r;
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

  // decoded control fields
  wire       bitDivPower  = bitRatio_r[`ASPC_PWR_BIT];              // [RL4]
  wire       wordDivPower = wordHigh_r[`ASPC_PWR_BIT];              // [RL6]
  wire [6:0] bitRatio     = bitRatio_r[`ASPC_RATIO_HI:0];           // [RL5]
  wire [9:0] wordRatio    = {wordHigh_r[`ASPC_WHIGH_HI:0], wordLow_r}; // [RL8]
  wire [2:0] bitSrcSel    = divSource_r[`ASPC_SRC_HI:`ASPC_SRC_LO];
  wire       multichip    = linkMode_r[`ASPC_LINK_BIT];             // [RL11]
  wire [2:0] devNumCode   = devNumber_r[`ASPC_DEVNUM_HI:0];         // [RL12]
  wire       isDeviceOne  = (devNumCode == 3'h0);                   // [RL12]
  // bit clock only driven by device one on a multichip link
  wire       bitDirOut    = divSource_r[`ASPC_BIT_DIR] & multichip & isDeviceOne; // [RL1]
  wire       wordDirOut   = divSource_r[`ASPC_WORD_DIR];            // [RL2]
  wire [3:0] bclkCode     = bclkPin_r[`ASPC_PIN_HI:`ASPC_PIN_LO];   // [RL9]
  wire [3:0] wclkCode     = wclkPin_r[`ASPC_PIN_HI:`ASPC_PIN_LO];   // [RL10]

  // pin code to input level; reserved codes read low
  wire [15:0] pinLevels = {1'b0, gpiIn, 2'b00, gpioIn};             // [RL9]

  // divider source mux; reserved source gives no clock
  reg srcLevel;                       // selected source level
  always @* begin
    case (bitSrcSel)                                                // [RL3]
      3'h0: srcLevel = nDividerClk;
      3'h1: srcLevel = dacModClk;
      3'h3: srcLevel = adcModClk;
      3'h4: srcLevel = portBitClkPins[0];
      3'h5: srcLevel = portBitClkPins[1];
      3'h6: srcLevel = portBitClkPins[2];
      3'h7: srcLevel = portBitClkPins[3];
      default: srcLevel = 1'b0;
    endcase
  end

  // rising-edge detect of the source, sampled as synchronous
  reg srcPrev_r;                      // previous source level
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      srcPrev_r <= 1'b0;
    end else begin
      srcPrev_r <= srcLevel;
    end
  end
  wire srcRise = srcLevel & ~srcPrev_r;

  wire bitTick;                       // one per bit clock half period
  wire wordTick;                      // one per word frame

  aspc_divider #(.W(7)) bitDiv (
    .clk     (clk),
    .rst_n   (rstSync_r),
    .powerUp (bitDivPower),                                         // [RL13]
    .stepIn  (srcRise),
    .ratio   (bitRatio),                                            // [RL5]
    .tickOut (bitTick)
  );

  aspc_divider #(.W(10)) wordDiv (
    .clk     (clk),
    .rst_n   (rstSync_r),
    .powerUp (wordDivPower & bitDivPower),                          // [RL13]
    .stepIn  (bitTick),
    .ratio   (wordRatio),                                           // [RL7]
    .tickOut (wordTick)
  );

  // clock outputs toggle per tick, forced low when powered down
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      bitClkOut  <= 1'b0;
      wordClkOut <= 1'b0;
    end else begin
      if (!bitDivPower) begin                                       // [RL13]
        bitClkOut <= 1'b0;
      end else if (bitTick) begin
        bitClkOut <= ~bitClkOut;
      end
      if (!(wordDivPower & bitDivPower)) begin                      // [RL13]
        wordClkOut <= 1'b0;
      end else if (wordTick) begin
        wordClkOut <= ~wordClkOut;
      end
    end
  end

  // pin routing; only gpio codes can be driven, input-only pins never
  integer i;
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      gpioOut   <= 10'h000;
      gpioOe    <= 10'h000;
      bitClkIn  <= 1'b0;
      wordClkIn <= 1'b0;
    end else begin
      bitClkIn  <= pinLevels[bclkCode];                             // [RL9]
      wordClkIn <= pinLevels[wclkCode];                             // [RL10]
      for (i = 0; i < 10; i = i + 1) begin
        // bit clock wins if both selects name the same pin
        if (bitDirOut && bitDivPower && bclkCode == i[3:0]) begin  // [RL1] [RL13]
          gpioOe[i]  <= 1'b1;
          gpioOut[i] <= bitClkOut;
        end else if (wordDirOut && wordDivPower && bitDivPower
                     && wclkCode == i[3:0]) begin                   // [RL2] [RL13]
          gpioOe[i]  <= 1'b1;
          gpioOut[i] <= wordClkOut;
        end else begin
          gpioOe[i]  <= 1'b0;
          gpioOut[i] <= 1'b0;
        end
      end
    end
  end
endmodule // aspc_clock_gen

/* File: bench/aspc_clock_gen_props.sv */
// port checker for the aux port clock generator, with its bind
`timescale 1ns/1ps
module aspc_clock_gen_props (
  input wire       clk,        // system clock
  input wire       nrst,       // reset, active low
  input wire       regWrite,   // write strobe
  input wire       regRead,    // read strobe
  input wire [7:0] regAddr,    // register address
  input wire [7:0] regWdata,   // write data
  input wire [7:0] regRdata,   // read data
  input wire [9:0] gpioIn,     // resolved pin levels
  input wire [2:0] gpiIn,      // input-only pins
  input wire [9:0] gpioOut,    // pin drive level
  input wire [9:0] gpioOe,     // pin drive enable
  input wire       bitClkIn,   // selected bit clock pin
  input wire       wordClkIn,  // selected word clock pin
  input wire       bitClkOut,  // generated bit clock
  input wire       wordClkOut  // generated word clock
);
  logic [7:0] sh [1:9];  // shadow of 0x61..0x69
  logic [3:0] st_r;      // cycles since last write, saturating
  wire pwrB = sh[5][7], pwrW = sh[6][7] & pwrB, dirW = sh[4][6];
  wire enB = sh[4][7] & sh[1][7] & (sh[2][2:0] == 3'h0);
  wire [3:0] bp = sh[8][6:3], wp = sh[9][6:3];
  wire bOk = bp < 4'hA || (bp > 4'hB && bp < 4'hF), wOk = wp < 4'hA || (wp > 4'hB && wp < 4'hF);
  wire bSel = bp < 4'hA ? gpioIn[bp] : gpiIn[bp[1:0]], wSel = wp < 4'hA ? gpioIn[wp] : gpiIn[wp[1:0]];
  wire mapped = regAddr[7:4] == 4'h6 && regAddr[3:0] inside {1, 2, [4:9]};
  // shadow follows writes so drive rules are judged from the ports alone
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh <= '{8'h08, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h20, 8'h40, 8'h38};
      st_r <= 4'h0;
    end else begin
      if (regWrite && regAddr[7:4] == 4'h6 && regAddr[3:0] inside {[1:9]}) sh[regAddr[3:0]] <= regWdata;
      st_r <= regWrite ? 4'h0 : st_r + {3'h0, st_r != 4'hF};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  bit_off_a: assert property (st_r > 3 && !pwrB |-> !bitClkOut)
    else $error("bit clock runs while powered down");
  word_off_a: assert property (st_r > 3 && !pwrW |-> !wordClkOut)
    else $error("word clock runs while powered down");
  bit_drive_a: assert property (st_r > 3 && enB && pwrB && bp < 4'hA
    |-> gpioOe[bp] && gpioOut[bp] == $past(bitClkOut)) else $error("bit clock not driven");
  bit_block_a: assert property (st_r > 3 && !enB && bp < 4'hA && !(dirW && wp == bp)
    |-> !gpioOe[bp]) else $error("bit clock pin driven while input");
  word_drive_a: assert property (st_r > 3 && dirW && pwrW && wp < 4'hA && !(enB && bp == wp)
    |-> gpioOe[wp] && gpioOut[wp] == $past(wordClkOut)) else $error("word clock not driven");
  word_block_a: assert property (st_r > 3 && !dirW && wp < 4'hA && !(enB && bp == wp)
    |-> !gpioOe[wp]) else $error("word clock pin driven while input");
  // with the bit divider down neither clock may reach any pin
  drive_off_a: assert property (st_r > 3 && !pwrB |-> gpioOe == 10'h000)
    else $error("clock pin driven while divider powered down");
  bit_pin_a: assert property (st_r > 3 && bOk |-> bitClkIn == $past(bSel))
    else $error("bit clock input from wrong pin");
  word_pin_a: assert property (st_r > 3 && wOk |-> wordClkIn == $past(wSel))
    else $error("word clock input from wrong pin");
  src_rsv_a: assert property (st_r > 5 && sh[4][2:0] == 3'h2 |=> $stable(bitClkOut))
    else $error("reserved source makes a clock");
  unmapped_rd_a: assert property (regRead && !mapped |-> ##1 regRdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (st_r > 3 && enB && pwrB);
  cover property (st_r > 3 && dirW && pwrW);
  cover property ($changed(wordClkOut));
endmodule // aspc_clock_gen_props
bind aspc_clock_gen aspc_clock_gen_props aspc_clock_gen_props_i (.clk, .nrst, .regWrite, .regRead,
  .regAddr, .regWdata, .regRdata, .gpioIn, .gpiIn, .gpioOut, .gpioOe, .bitClkIn, .wordClkIn,
  .bitClkOut, .wordClkOut);

/* File: bench/aspc_far_end.sv */
// peer model that drives the shared clock pins wherever the block does not
`timescale 1ns/1ps
module aspc_far_end (
  input  wire        clk,     // system clock
  input  wire  [9:0] gpioOe,  // block drive enables
  input  wire  [9:0] gpioOut, // block drive levels
  output logic [9:0] gpioIn,  // resolved pin levels
  output logic [2:0] gpiIn    // input-only pin levels
);
  logic [12:0] peer_r = 13'h0A5; // peer master clock pattern
  // pattern moves every cycle; only bit 0 flips each cycle, so a stale level on other pins can pass for a selected one
  always @(negedge clk) peer_r <= peer_r + 13'h0B3;
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & peer_r[9:0]);
  assign gpiIn  = peer_r[12:10];
endmodule // aspc_far_end

/* File: bench/testbench.sv */
// self-checking bench for the aux port clock generator
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0, nrst = 1'b0;          // clock, reset active low
  logic       regWrite = 1'b0, regRead = 1'b0;  // register strobes
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rv, gv;
  logic [6:0] sc = 7'h00;                        // source clock chain, periods 2..128
  logic [9:0] gpioIn, gpioOut, gpioOe;           // pin side
  logic [2:0] gpiIn;                             // input-only pins
  logic       bitClkIn, wordClkIn, bitClkOut, wordClkOut;
  logic [7:0] ra [8] = '{8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69};
  logic [7:0] re [8] = '{8'h08, 8'h00, 8'h01, 8'h02, 8'h00, 8'h20, 8'h40, 8'h38};
  logic [9:0] wn [4] = '{10'h003, 10'h101, 10'h000, 10'h2C7}; // word ratios, 0 means 1024
  int bad_count = 0, num_checks = 0, cyc = 0, n, i, s, r, bc, wc;
  aspc_clock_gen aspc_clock_gen_i (.clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .nDividerClk(sc[0]), .dacModClk(sc[1]), .adcModClk(sc[2]),
    .portBitClkPins(sc[6:3]), .gpioIn, .gpiIn, .gpioOut, .gpioOe, .bitClkIn, .wordClkIn,
    .bitClkOut, .wordClkOut);
  aspc_far_end aspc_far_end_i (.clk, .gpioOe, .gpioOut, .gpioIn, .gpiIn);
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) sc <= sc + 7'h01;
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      close_out;
    end
  end
  task close_out;
    $display("comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write pulse; leading edge wait keeps back-to-back strobes apart
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 0;
    @(negedge clk);
    d = regRdata;
  endtask
  // cycles between two toggles of a clock output, 3000 if it stands still
  task gap(input bit w, output int n);
    logic l;
    l = w ? wordClkOut : bitClkOut;
    for (n = 0; n < 3000 && (w ? wordClkOut : bitClkOut) === l; n++) @(negedge clk);
    l = w ? wordClkOut : bitClkOut;
    for (n = 0; n < 3000 && (w ? wordClkOut : bitClkOut) === l; n++) @(negedge clk);
  endtask
  // half period: ratio times the source period (source code skips reserved 2)
  function int bexp(int s, int r);
    return (r == 0 ? 128 : r) << (s - (s > 2) + 1);
  endfunction
  function int wexp(int w);
    return (w == 0 ? 1024 : w) * 2;
  endfunction
  initial begin
    void'($urandom(32'h0484));
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    // reset values, then random write and read back, then unmapped place
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, re[i]);
    end
    foreach (ra[i]) begin
      rv = $urandom;
      wr(ra[i], rv);
      rd(ra[i], gv);
      chk(gv, rv);
    end
    wr(8'h70, 8'hFF);
    rd(8'h70, rv);
    chk(rv, 8'h00);
    // every source code, last pass ratio 0 on the fastest source
    for (s = 0; s < 9; s++) begin
      r = (s == 8) ? 0 : 1 + $urandom % 3;
      // power down first: a stale count above the new ratio would wrap for ages
      wr(8'h65, 8'h00);
      wr(8'h64, 8'(s % 8));
      wr(8'h65, 8'(8'h80 | r));
      gap(0, n);
      chk(n, s == 2 ? 3000 : bexp(s % 8, r));
    end
    wr(8'h65, 8'h01);
    repeat (8) @(negedge clk);
    chk(bitClkOut, 1'b0);
    wr(8'h64, 8'h00);
    wr(8'h65, 8'h81);
    foreach (wn[i]) begin
      wr(8'h66, {6'h20, wn[i][9:8]});
      wr(8'h67, wn[i][7:0]);
      gap(1, n);
      chk(n, wexp(wn[i]));
    end
    wr(8'h66, 8'h03);
    repeat (8) @(negedge clk);
    chk(wordClkOut, 1'b0);
    wr(8'h66, 8'h80);
    // random pin codes, directions, link type and device number
    for (i = 0; i < 12; i++) begin
      bc = $urandom % 10;
      wc = (i % 4 == 3) ? 12 + $urandom % 3 : (bc + 1 + $urandom % 9) % 10;
      s = $urandom % 4;
      r = $urandom % 4;
      wr(8'h68, 8'(bc << 3));
      wr(8'h69, 8'(wc << 3));
      wr(8'h61, {r[1], 7'h00});
      wr(8'h62, {7'h00, r[0]});
      wr(8'h64, 8'(s << 6));
      repeat (6) @(negedge clk);
      chk(gpioOe[bc], s[1] & r[1] & ~r[0]);
      if (wc < 10) chk(gpioOe[wc], s[0]);
    end
    // mid-run reset brings registers back and releases every pin
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h65, rv);
    chk(rv, 8'h02);
    chk(gpioOe, 10'h000);
    close_out;
  end
endmodule // testbench
